// ---- src/pad_strap_config_store.v ----
/*
 * Pad strap configuration store: times the store pad, decodes the select
 * and level pads on release, and keeps sensitivity, dwell and mode in a
 * retained store. Also drives the logic and relay sink outputs, with an
 * APB slave for readback and software stores.
 * Assumes pad inputs are already synchronous and debounced, the level
 * pad arrives as a decoded code, and the retained store is a power-domain
 * register cell whose contents survive loss of supply (nv_* inputs load it).
 */
`timescale 1ns/1ps
`include "pad_strap_map.vh"

// What this block does
// RULE1: Commit selection after one second hold, release
// RULE2: Settings persist, change only on store
// RULE3: Each store updates only selected function
// RULE4: Open selects set sensitivity from level
// RULE5: Pad a grounded sets short dwell
// RULE6: Pad b grounded sets long dwell
// RULE7: Both grounded set output mode
// RULE8: All grounded restores every default
// RULE9: Programmer powers module before storing
// RULE10: Programmer follows select, level, store order
// RULE11: Programmer removes straps after programming
// RULE12: Logic output high on motion
// RULE13: Relay sink output inverts logic output
// RULE14: Level code sampled with selects on store
// RULE15: Short hold or undefined pads change nothing
module pad_strap_config_store #(
	parameter HOLD_CYCLES = `STORE_HOLD_CYCLES // Store pad hold time in cycles
) (
	input wire clk, // 200 MHz clock
	input wire reset_n, // Asynchronous reset, active low
	input wire select_pad_a_n, // Select pad a, low when grounded
	input wire select_pad_b_n, // Select pad b, low when grounded
	input wire [2:0] level_resistor_pad, // Decoded level pad code
	input wire store_pad_n, // Store pad, low when grounded
	input wire nv_valid, // Retained store holds valid contents
	input wire [2:0] nv_sens, // Retained sensitivity
	input wire [3:0] nv_dwell, // Retained dwell
	input wire nv_mode, // Retained mode
	input wire motion, // Motion present, from detector
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB write
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error
	output reg [2:0] sensitivity, // Stored sensitivity
	output reg [3:0] dwell, // Stored dwell code
	output reg mode, // Stored output mode
	output reg nv_write, // Pulse: write retained store
	output reg logic_output, // High on motion
	output reg relay_sink_output // Low (sinking) on motion
);

	localparam ST_IDLE = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_ARMED = 2'h2;
	localparam ST_LOAD = 2'h3;
	localparam CW = 32;
	// Last count of the hold, held at the counter's own width
	localparam [CW-1:0] HOLD_LAST = HOLD_CYCLES - 1;

	reg [1:0] state;
	reg [CW-1:0] hold_count;
	reg [2:0] lvl_q;
	reg sel_a_q;
	reg sel_b_q;
	reg store_req;
	reg sw_store;
	reg [2:0] sw_level;
	reg [1:0] sw_sel;
	reg [15:0] store_count;
	reg [15:0] abort_count;
	wire wr_sens;
	wire wr_dwell;
	wire wr_mode;
	wire [2:0] dec_sens;
	wire [3:0] dec_dwell;
	wire dec_mode;
	wire apb_access;
	wire apb_write;
	wire hold_done;

	// Saturating counter increment
	function [15:0] sat_inc;
		input [15:0] v;
		begin
			sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
		end
	endfunction

	assign hold_done = (hold_count >= HOLD_LAST);
	assign apb_access = psel & penable & pready;
	assign apb_write = apb_access & pwrite;

	// Decoder for the latched pad combination
	setting_decoder u_dec (
		.sel_a(sel_a_q),
		.sel_b(sel_b_q),
		.level(lvl_q),
		.wr_sens(wr_sens),
		.wr_dwell(wr_dwell),
		.wr_mode(wr_mode),
		.sens(dec_sens),
		.dwell(dec_dwell),
		.mode(dec_mode)
	);

	// Store pad timing; pads captured at release
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_LOAD;
			hold_count <= 32'h0000_0000;
			lvl_q <= `LVL_GND;
			sel_a_q <= 1'b0;
			sel_b_q <= 1'b0;
			store_req <= 1'b0;
			abort_count <= 16'h0000;
		end else begin
			store_req <= 1'b0;
			case (state)
			ST_LOAD: begin
				state <= ST_IDLE;
			end
			ST_IDLE: begin
				hold_count <= 32'h0000_0000;
				if (sw_store) begin
					sel_a_q <= sw_sel[0];
					sel_b_q <= sw_sel[1];
					lvl_q <= sw_level;
					store_req <= 1'b1;
				end else if (!store_pad_n) begin
					state <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (store_pad_n) begin
					state <= ST_IDLE; // see RULE15
					abort_count <= sat_inc(abort_count);
				end else if (hold_done) begin
					state <= ST_ARMED; // see RULE1
				end else begin
					hold_count <= hold_count + 32'h0000_0001;
				end
			end
			default: begin
				// Held long enough; commit on opening
				if (store_pad_n) begin
					sel_a_q <= ~select_pad_a_n; // see RULE14
					sel_b_q <= ~select_pad_b_n;
					lvl_q <= level_resistor_pad;
					store_req <= 1'b1; // see RULE1
					state <= ST_IDLE;
				end
			end
			endcase
		end
	end

	// Settings: loaded from retained store, then only by stores
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sensitivity <= `SENS_MED;
			dwell <= `DWELL_1S;
			mode <= `MODE_RETRIG;
			nv_write <= 1'b0;
			store_count <= 16'h0000;
		end else begin
			nv_write <= 1'b0;
			if (state == ST_LOAD && nv_valid) begin
				sensitivity <= nv_sens; // see RULE2
				dwell <= nv_dwell;
				mode <= nv_mode;
			end else if (store_req && (wr_sens | wr_dwell | wr_mode)) begin
				// Only the selected function moves
				if (wr_sens)
					sensitivity <= dec_sens; // see RULE3
				if (wr_dwell)
					dwell <= dec_dwell; // see RULE3
				if (wr_mode)
					mode <= dec_mode; // see RULE3
				nv_write <= 1'b1; // see RULE2
				store_count <= sat_inc(store_count);
			end
		end
	end

	// Output drivers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			logic_output <= 1'b0;
			relay_sink_output <= 1'b1;
		end else begin
			logic_output <= motion; // see RULE12
			relay_sink_output <= ~motion; // see RULE13
		end
	end

	// APB slave: one wait state, error on unmapped address
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			sw_store <= 1'b0;
			sw_level <= `LVL_GND;
			sw_sel <= 2'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (state == ST_IDLE)
				sw_store <= 1'b0;
			if (psel & penable & ~pready) begin
				prdata <= 32'h0000_0000;
				if (paddr == `REG_SETTINGS) begin
					prdata <= {23'h000000, mode, dwell, 1'b0, sensitivity};
				end else if (paddr == `REG_STATUS) begin
					prdata <= {28'h0000000, store_pad_n, sw_store, state};
				end else if (paddr == `REG_STORES) begin
					prdata <= {abort_count, store_count};
				end else begin
					pslverr <= 1'b1;
				end
			end
			if (apb_write && paddr == `REG_STATUS && !sw_store) begin
				// Software store: bits 2:0 level, 5:4 selects (b,a)
				sw_level <= pwdata[2:0];
				sw_sel <= pwdata[5:4];
				sw_store <= pwdata[8];
			end
		end
	end

endmodule // pad_strap_config_store

// ---- src/pad_strap_map.vh ----
/*
 * Constants for the pad strap configuration store: pad level codes,
 * setting encodings, defaults, timing and register map.
 * Assumes a 200 MHz clock; included by bare name.
 */
`ifndef PAD_STRAP_MAP_VH
`define PAD_STRAP_MAP_VH

// Clock rate and store hold time
`define CLK_HZ 200000000
`define STORE_HOLD_MS 1000
`define STORE_HOLD_CYCLES (`CLK_HZ / 1000 * `STORE_HOLD_MS)

// Decoded level pad codes
`define LVL_GND 3'h0
`define LVL_2K7 3'h1
`define LVL_6K8 3'h2
`define LVL_15K 3'h3
`define LVL_39K 3'h4

// Sensitivity codes
`define SENS_MIN 3'h0
`define SENS_LOW 3'h1
`define SENS_MED 3'h2
`define SENS_HIGH 3'h3
`define SENS_MAX 3'h4

// Dwell codes, in order of length
`define DWELL_0S2 4'h0
`define DWELL_1S 4'h1
`define DWELL_2S 4'h2
`define DWELL_5S 4'h3
`define DWELL_10S 4'h4
`define DWELL_30S 4'h5
`define DWELL_1M 4'h6
`define DWELL_2M 4'h7
`define DWELL_5M 4'h8
`define DWELL_10M 4'h9

// Output modes
`define MODE_RETRIG 1'h0
`define MODE_SINGLE 1'h1

// Register byte offsets
`define REG_SETTINGS 12'h000
`define REG_STATUS 12'h004
`define REG_STORES 12'h008

// Settings register field positions
`define SET_SENS_LSB 0
`define SET_DWELL_LSB 4
`define SET_MODE_BIT 8

`endif

// ---- src/setting_decoder.v ----
/*
 * Decodes the select pads and level code into one setting update.
 * Purely combinational; pads are active high when grounded.
 */
`timescale 1ns/1ps
`include "pad_strap_map.vh"

module setting_decoder (
	input wire sel_a, // Select pad a grounded
	input wire sel_b, // Select pad b grounded
	input wire [2:0] level, // Level pad code
	output reg wr_sens, // Update sensitivity
	output reg wr_dwell, // Update dwell
	output reg wr_mode, // Update mode
	output reg [2:0] sens, // New sensitivity
	output reg [3:0] dwell, // New dwell
	output reg mode // New mode
);

	// Table lookup of the pad combination
	always @* begin
		wr_sens = 1'b0;
		wr_dwell = 1'b0;
		wr_mode = 1'b0;
		sens = `SENS_MED;
		dwell = `DWELL_1S;
		mode = `MODE_RETRIG;
		case ({sel_a, sel_b})
		2'b00: begin
			wr_sens = (level <= `LVL_39K); // see RULE4
			case (level)
			`LVL_2K7: sens = `SENS_MIN;
			`LVL_6K8: sens = `SENS_LOW;
			`LVL_15K: sens = `SENS_HIGH;
			`LVL_39K: sens = `SENS_MAX;
			default: sens = `SENS_MED;
			endcase
		end
		2'b10: begin
			wr_dwell = (level <= `LVL_39K); // see RULE5
			case (level)
			`LVL_2K7: dwell = `DWELL_0S2;
			`LVL_6K8: dwell = `DWELL_2S;
			`LVL_15K: dwell = `DWELL_5S;
			`LVL_39K: dwell = `DWELL_10S;
			default: dwell = `DWELL_1S;
			endcase
		end
		2'b01: begin
			wr_dwell = (level <= `LVL_39K); // see RULE6
			case (level)
			`LVL_2K7: dwell = `DWELL_1M;
			`LVL_6K8: dwell = `DWELL_2M;
			`LVL_15K: dwell = `DWELL_5M;
			`LVL_39K: dwell = `DWELL_10M;
			default: dwell = `DWELL_30S;
			endcase
		end
		default: begin
			// Ground restores all; 15k and 39k undefined
			if (level == `LVL_GND) begin // see RULE8
				wr_sens = 1'b1;
				wr_dwell = 1'b1;
				wr_mode = 1'b1;
			end else if (level == `LVL_2K7) begin // see RULE7
				wr_mode = 1'b1;
			end else if (level == `LVL_6K8) begin // see RULE7
				wr_mode = 1'b1;
				mode = `MODE_SINGLE;
			end
		end
		endcase
	end

endmodule // setting_decoder

// ---- tb/pad_strap_props.sv ----
/* Port checker for the pad strap store.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ps
module pad_strap_props #(
	parameter HOLD_CYCLES = 20 // Store hold cycles
) (
	input wire clk, // Clock
	input wire reset_n, // Reset, active low
	input wire store_pad_n, // Store pad
	input wire motion, // Motion in
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB write
	input wire [11:0] paddr, // APB address
	input wire [31:0] prdata, // APB read data
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire [2:0] sensitivity, // Sensitivity
	input wire [3:0] dwell, // Dwell
	input wire mode, // Mode
	input wire nv_write, // Store pulse
	input wire logic_output, // Logic out
	input wire relay_sink_output // Relay sink
);
	int low_cnt;
	// Consecutive low store pad edges
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			low_cnt <= 0;
		else
			low_cnt <= store_pad_n ? 0 : low_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence short_release;
		$rose(store_pad_n) && low_cnt < HOLD_CYCLES - 1;
	endsequence
	sequence access_start;
		psel && penable && !$past(penable);
	endsequence
	chk_short_noop: assert property (short_release |-> ##1 (!nv_write && $stable({mode, dwell, sensitivity}))[*3])
		else $error("store committed after a short hold");
	chk_change_pulse: assert property ($changed({mode, dwell, sensitivity}) && $past(reset_n, 2) |-> nv_write)
		else $error("settings changed without a store");
	chk_pulse_once: assert property (nv_write |=> !nv_write)
		else $error("store pulse longer than one cycle");
	chk_logic_motion: assert property ($past(reset_n) |-> logic_output == $past(motion))
		else $error("logic output does not follow motion");
	chk_relay_inv: assert property (relay_sink_output != logic_output)
		else $error("relay output not inverse of logic output");
	chk_apb_wait: assert property (access_start |-> !pready ##1 pready)
		else $error("ready not one cycle into access");
	chk_ready_once: assert property (pready |-> psel && penable ##1 !pready)
		else $error("ready outside access or too long");
	chk_err_unmapped: assert property (pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008))
		else $error("error flag wrong for address");
	chk_read_settings: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[8:0] == $past({mode, dwell, 1'b0, sensitivity}))
		else $error("settings readback mismatch");
endmodule // pad_strap_props

bind pad_strap_config_store pad_strap_props #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (
	.clk(clk), .reset_n(reset_n), .store_pad_n(store_pad_n), .motion(motion), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sensitivity(sensitivity), .dwell(dwell), .mode(mode),
	.nv_write(nv_write), .logic_output(logic_output), .relay_sink_output(relay_sink_output));

// ---- tb/strap_fixture.sv ----
/* Programming fixture: straps select, level and store pads.
   Assumes pads read high when open; level code 7 means no resistor. */
`timescale 1ns/1ps
module strap_fixture (
	input wire clk, // Clock
	input wire reset_n, // Module powered
	output logic select_pad_a_n, // Select pad a
	output logic select_pad_b_n, // Select pad b
	output logic [2:0] level_resistor_pad, // Level code
	output logic store_pad_n // Store pad
);
	// All pads open
	initial begin
		select_pad_a_n = 1'h1;
		select_pad_b_n = 1'h1;
		level_resistor_pad = 3'h7;
		store_pad_n = 1'h1;
	end
	// One programming pass
	task automatic strap(input logic sa, sb, input logic [2:0] l, input int hold);
		wait (reset_n === 1'h1);
		@(posedge clk);
		select_pad_a_n <= !sa;
		select_pad_b_n <= !sb;
		@(posedge clk);
		level_resistor_pad <= l;
		@(posedge clk);
		store_pad_n <= 1'h0;
		repeat (hold) @(posedge clk);
		store_pad_n <= 1'h1;
		repeat (3) @(posedge clk);
		select_pad_a_n <= 1'h1;
		select_pad_b_n <= 1'h1;
		level_resistor_pad <= 3'h7;
	endtask
endmodule // strap_fixture

// ---- tb/testbench.sv ----
/* Self-checking bench for the pad strap store.
   Assumes the fixture model drives the pads; retained cell modelled here. */
`timescale 1ns/1ps
`include "pad_strap_map.vh"
module testbench;
	localparam int HOLD = 20;
	logic clk = 1'h0, reset_n = 1'h0, motion = 1'h0, nv_valid = 1'h0, nv_mode = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sa, sb, err, e_mode;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [2:0] nv_sens = '0, sensitivity, level_resistor_pad, lvl, e_sens;
	logic [3:0] nv_dwell = '0, dwell, e_dwell;
	logic select_pad_a_n, select_pad_b_n, store_pad_n, pready, pslverr, mode, nv_write;
	logic logic_output, relay_sink_output, m_q;
	int seed = 32'h40dc653e, fails = 0, n_tests = 0, cyc = 0, hold;
	pad_strap_config_store #(.HOLD_CYCLES(HOLD)) dut_u (.clk(clk), .reset_n(reset_n),
		.select_pad_a_n(select_pad_a_n), .select_pad_b_n(select_pad_b_n),
		.level_resistor_pad(level_resistor_pad), .store_pad_n(store_pad_n), .nv_valid(nv_valid),
		.nv_sens(nv_sens), .nv_dwell(nv_dwell), .nv_mode(nv_mode), .motion(motion), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sensitivity(sensitivity), .dwell(dwell), .mode(mode),
		.nv_write(nv_write), .logic_output(logic_output), .relay_sink_output(relay_sink_output));
	strap_fixture fx_u (.clk(clk), .reset_n(reset_n), .select_pad_a_n(select_pad_a_n),
		.select_pad_b_n(select_pad_b_n), .level_resistor_pad(level_resistor_pad),
		.store_pad_n(store_pad_n));
	always #2.5 clk = ~clk;
	// Random motion, retained cell and run limit
	always @(posedge clk) begin
		motion <= $random(seed);
		m_q <= motion;
		cyc++;
		if (cyc > 6000) begin
			fails++;
			finish_test();
		end
	end
	always @(posedge clk) if (nv_write === 1'h1) begin
		nv_sens <= sensitivity;
		nv_dwell <= dwell;
		nv_mode <= mode;
	end
	// Expected settings after one strap pass
	function automatic void apply(input logic a, b, input logic [2:0] l);
		if (l > 3'h4) return;
		case ({a, b})
			2'b00: e_sens = (l == 3'h0) ? `SENS_MED : (l == 3'h1) ? `SENS_MIN : (l == 3'h2) ? `SENS_LOW : l;
			2'b10: e_dwell = (l == 3'h0) ? `DWELL_1S : (l == 3'h1) ? `DWELL_0S2 : {1'h0, l};
			2'b01: e_dwell = 4'h5 + l;
			default: if (l == 3'h0) begin
				e_sens = `SENS_MED;
				e_dwell = `DWELL_1S;
				e_mode = `MODE_RETRIG;
			end else if (l < 3'h3) e_mode = (l == 3'h2);
		endcase
	endfunction
	task automatic cmp_word(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp_set(input string nm);
		cmp_word(nm, {23'h0, e_mode, e_dwell, 1'h0, e_sens}, {23'h0, mode, dwell, 1'h0, sensitivity});
	endtask
	// One APB transfer, waits for ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic finish_test();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		e_sens = `SENS_MED;
		e_dwell = `DWELL_1S;
		e_mode = `MODE_RETRIG;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		repeat (2) @(posedge clk);
		#1 cmp_set("defaults");
		for (int i = 0; i < 80; i++) begin
			lvl = (i < 32) ? i[2:0] : $random(seed);
			sa = (i < 32) ? i[3] : $random(seed);
			sb = (i < 32) ? i[4] : $random(seed);
			hold = (i < 32) ? HOLD + 2 : (i % 3 == 0) ? HOLD - 2 : HOLD + 1;
			fx_u.strap(sa, sb, lvl, hold);
			@(posedge clk);
			#1;
			if (hold > HOLD) apply(sa, sb, lvl);
			cmp_set("store");
			cmp_word("logic out", {31'h0, m_q}, {31'h0, logic_output});
			cmp_word("relay out", {31'h0, !m_q}, {31'h0, relay_sink_output});
		end
		apb(1'h0, 12'h000, '0, rd, err);
		cmp_word("settings read", {23'h0, e_mode, e_dwell, 1'h0, e_sens}, rd);
		apb(1'h1, 12'h000, $random(seed), rd, err);
		apb(1'h0, 12'h010, '0, rd, err);
		cmp_word("unmapped err", 32'h1, {31'h0, err});
		@(posedge clk);
		#1 cmp_set("after write");
		// Software store: select b grounded, 39k level, commit bit set
		apb(1'h1, 12'h004, 32'h0000_0124, rd, err);
		cmp_word("status err", 32'h0, {31'h0, err});
		repeat (3) @(posedge clk);
		#1 apply(1'h0, 1'h1, 3'h4);
		cmp_set("software store");
		@(posedge clk);
		nv_valid <= 1'h1;
		reset_n <= 1'h0;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		repeat (2) @(posedge clk);
		#1 cmp_set("retained");
		finish_test();
	end
endmodule // testbench
